// >>> sft_map.vh
// Register map, field positions, reset values and timing constants
`ifndef SFT_MAP_VH
`define SFT_MAP_VH
// Notes on behaviour
// - Disabled channel floats; enabled channel drives frames
// - Tick period set in 8 ns steps
// - Tick period never below 1.504 us
// - Nibble low portion lasts configured tick count
// - Variable mode: frames back to back, no pause
// - Constant mode: pause pads frame to total
// - Total frame length only used in constant mode
// - Rolling counter replaces nibbles four and five
// - Only configured data nibble count is sent
// - Mode 0: legacy checksum
// - Mode 1: recommended checksum with zero nibble
// - Mode 2 sends 0x0, mode 3 sends 0xF
// - Mode by signal picks 0..3, else zero
// - Data by signal sends selector as checksum
// - Four-bit driver state: level, overcurrents, error
// - Active and inactive levels selectable
// - One instance per channel, up to sixteen
// - Nibble values come from model inputs
// Byte offsets on the register bus
`define SFT_CTRL_OFS 8'h00
`define SFT_TICK_OFS 8'h04
`define SFT_LOWT_OFS 8'h08
`define SFT_FLEN_OFS 8'h0C
`define SFT_NDAT_OFS 8'h10
`define SFT_NIBV_OFS 8'h14
`define SFT_CSEL_OFS 8'h18
`define SFT_STAT_OFS 8'h1C
// Control fields
`define SFT_CTRL_EN 0
`define SFT_CTRL_ROLL 1
`define SFT_CTRL_CONST 2
`define SFT_CTRL_CSM_LO 4
`define SFT_CTRL_ACT_LO 8
`define SFT_CTRL_INACT_LO 10
// Reset values
`define SFT_CTRL_RST 16'h0400
`define SFT_TICK_RST 14'h0177
`define SFT_LOWT_RST 8'h05
`define SFT_FLEN_RST 16'h0200
`define SFT_NDAT_RST 3'h6
// Timing: times in ns, segment lengths in ticks, tick step 8 ns, clock 25 ns
`define SFT_CLK_NS 25
`define SFT_STEP_NS 8
`define SFT_TMIN_NS 1504
`define SFT_TMIN_STEPS (`SFT_TMIN_NS / `SFT_STEP_NS)
`define SFT_CAL_TICKS 16'h0038
`define SFT_NIB_BASE 16'h000C
`define SFT_PAUSE_MIN 16'h000C
// Output level codes
`define SFT_LVL_OPEN 2'd0
`define SFT_LVL_GND 2'd1
`define SFT_LVL_BATA 2'd2
`define SFT_LVL_BATB 2'd3
`endif

// >>> sft_rx_model.sv
// Receiver model: measures rise-to-rise segment lengths in ticks
module sft_rx_model #(
  parameter int TICK_NS = 1504,
  parameter int CLK_NS = 25
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Driver switch enables
  input wire logic drv_gnd_en,
  input wire logic drv_bata_en,
  input wire logic drv_batb_en
);
  timeunit 1ns;
  timeprecision 1ps;
  int seg_q[$]; // Measured segments in ticks
  int cnt; // Clocks since last rise
  logic act_d; // Active level one sample back
  logic armed; // A rise has been seen since the line floated
  // Sampled on the falling edge, away from the transmitter's updates
  always @(negedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt = 0;
      act_d = 0;
      armed = 0;
    end
    else
    begin
      cnt++;
      // Floating line: framing lost, next rise starts afresh
      if (!(drv_gnd_en || drv_bata_en || drv_batb_en))
        armed = 0;
      else if (drv_bata_en && !act_d)
      begin
        if (armed)
          seg_q.push_back((cnt * CLK_NS + TICK_NS / 2) / TICK_NS);
        armed = 1;
        cnt = 0;
      end
      act_d = drv_bata_en;
    end
  end
endmodule

// >>> sft_tx.v
// SENT frame transmitter channel with AHB-Lite register slave
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`include "sft_map.vh"
module sft_tx #(
  parameter CHAN_ID = 0
)(
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Overcurrent flags from the driver stage
  input wire oc_low_in,
  input wire oc_high_in,
  // Driver switch enables, none high means floating
  output wire drv_gnd_en,
  output wire drv_bata_en,
  output wire drv_batb_en,
  // Driver state word
  output wire [3:0] driver_state_word
);

  // Frame states
  localparam ST_IDLE = 2'd0;
  localparam ST_CAL = 2'd1;
  localparam ST_NIB = 2'd2;
  localparam ST_PAUSE = 2'd3;

  // Configuration registers
  reg [15:0] ctrl_reg;
  reg [13:0] tick_reg;
  reg [7:0] lowt_reg;
  reg [15:0] flen_reg;
  reg [2:0] ndat_reg;
  reg [27:0] nibv_reg;
  reg [3:0] csel_reg;
  // Bus data phase capture
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg [31:0] rdata_reg;
  // Synchronisers for the overcurrent pins
  reg [1:0] ocl_sync_reg;
  reg [1:0] och_sync_reg;
  // Tick divider accumulator in ns
  reg [17:0] acc_reg;
  // Frame engine
  reg [1:0] state_reg;
  reg [2:0] nidx_reg;
  reg [15:0] seg_cnt_reg;
  reg [15:0] seg_len_reg;
  reg [15:0] frm_cnt_reg;
  reg [27:0] lat_nib_reg;
  reg [3:0] lat_crc_reg;
  reg [2:0] lat_ndat_reg;
  reg [7:0] roll_reg;
  reg act_reg;

  // Field views of control
  wire en = ctrl_reg[`SFT_CTRL_EN];
  wire roll_en = ctrl_reg[`SFT_CTRL_ROLL];
  wire const_en = ctrl_reg[`SFT_CTRL_CONST];
  wire [2:0] csm = ctrl_reg[`SFT_CTRL_CSM_LO +: 3];
  wire [1:0] act_lvl = ctrl_reg[`SFT_CTRL_ACT_LO +: 2];
  wire [1:0] inact_lvl = ctrl_reg[`SFT_CTRL_INACT_LO +: 2];

  // Nibble from a packed word by index
  function [3:0] nib_at;
    input [27:0] w;
    input [2:0] i;
    begin
      nib_at = w[i*4 +: 4];
    end
  endfunction

  // One step of the 4-bit checksum table walk
  function [3:0] crc_step;
    input [3:0] c;
    input [3:0] d;
    reg [63:0] tab;
    begin
      tab = 64'h5_8_2_F_B_6_C_1_4_9_3_E_A_7_D_0;
      crc_step = d ^ tab[c*4 +: 4];
    end
  endfunction

  // Checksum over the data nibbles only
  function [3:0] crc_calc;
    input [27:0] w;
    input [2:0] n;
    input rec;
    reg [3:0] c;
    integer k;
    begin
      c = 4'h5;
      for (k = 1; k <= 6; k = k + 1)
      begin
        if (k <= n)
          c = crc_step(c, w[k*4 +: 4]);
      end
      // Extra zero nibble strengthens the newer scheme
      if (rec)
        c = crc_step(c, 4'h0);
      crc_calc = c;
    end
  endfunction

  // Bus always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // Effective tick period, clamped to the floor
  wire [13:0] tick_eff = (tick_reg < `SFT_TMIN_STEPS) ?
    14'd188 : tick_reg;
  // Tick period in ns, granularity 8 ns
  wire [17:0] tick_ns = {1'b0, tick_eff, 3'b000};
  wire [17:0] acc_sum = acc_reg + 18'd25;
  wire tick = en && (acc_sum >= tick_ns);

  // Model inputs with rolling counter substituted
  wire [27:0] nib_src = roll_en ?
    {nibv_reg[27:24], roll_reg[3:0], roll_reg[7:4], nibv_reg[15:0]} :
    nibv_reg;
  // Number of data nibbles, one to six
  wire [2:0] ndat_eff = (ndat_reg == 3'd0) ? 3'd1 :
    ((ndat_reg > 3'd6) ? 3'd6 : ndat_reg);

  // Checksum nibble for the frame about to start
  reg [3:0] crc_sel;
  reg [2:0] mode_eff;
  always @*
  begin
    crc_sel = 4'h0;
    mode_eff = csm;
    // Mode by signal, out of range gives zero
    if (csm == 3'd4)
      mode_eff = (csel_reg < 4'd4) ? csel_reg[2:0] : 3'd7;
    case (mode_eff)
      3'd0: crc_sel = crc_calc(nib_src, ndat_eff, 1'b0);
      3'd1: crc_sel = crc_calc(nib_src, ndat_eff, 1'b1);
      3'd2: crc_sel = 4'h0;
      3'd3: crc_sel = 4'hF;
      3'd5: crc_sel = csel_reg;
      default: crc_sel = 4'h0;
    endcase
  end

  // Index and value of the next nibble: status, data, checksum
  // Shared by every nibble segment change, so one adder serves all
  wire [2:0] nidx_nxt = (state_reg == ST_CAL) ? 3'd0 : nidx_reg + 3'd1;
  wire [3:0] nxt_val = (nidx_nxt > lat_ndat_reg) ? lat_crc_reg :
    nib_at(lat_nib_reg, nidx_nxt);
  wire [15:0] nib_len = `SFT_NIB_BASE + {12'h000, nxt_val};
  wire seg_end = tick && (seg_cnt_reg + 16'd1 >= seg_len_reg);
  wire last_nib = (nidx_reg > lat_ndat_reg);
  // Pause length pads the frame to the total
  wire [15:0] frm_done = frm_cnt_reg + 16'd1;
  wire [15:0] pause_len = (flen_reg > frm_done + `SFT_PAUSE_MIN) ?
    flen_reg - frm_done : `SFT_PAUSE_MIN;

  // AHB address phase capture and read data
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end
    else if (hready)
    begin
      // Only nonsequential or sequential transfers, of any size; hsize is not checked
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= haddr;
      rdata_reg <= 32'h0000_0000;
      if (hsel && htrans[1] && !hwrite)
      begin
        case (haddr)
          `SFT_CTRL_OFS: rdata_reg <= {16'h0000, ctrl_reg};
          `SFT_TICK_OFS: rdata_reg <= {18'h0_0000, tick_reg};
          `SFT_LOWT_OFS: rdata_reg <= {24'h00_0000, lowt_reg};
          `SFT_FLEN_OFS: rdata_reg <= {16'h0000, flen_reg};
          `SFT_NDAT_OFS: rdata_reg <= {29'h0000_0000, ndat_reg};
          `SFT_NIBV_OFS: rdata_reg <= {4'h0, nibv_reg};
          `SFT_CSEL_OFS: rdata_reg <= {28'h000_0000, csel_reg};
          // Live state: roll counter, frame state, driver state
          `SFT_STAT_OFS: rdata_reg <= {16'h0000, roll_reg, 2'b00,
            state_reg, driver_state_word};
          // Unmapped reads return zero
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes in the data phase
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `SFT_CTRL_RST;
      tick_reg <= `SFT_TICK_RST;
      lowt_reg <= `SFT_LOWT_RST;
      flen_reg <= `SFT_FLEN_RST;
      ndat_reg <= `SFT_NDAT_RST;
      nibv_reg <= 28'h000_0000;
      csel_reg <= 4'h0;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        `SFT_CTRL_OFS: ctrl_reg <= hwdata[15:0];
        `SFT_TICK_OFS: tick_reg <= hwdata[13:0];
        `SFT_LOWT_OFS: lowt_reg <= hwdata[7:0];
        `SFT_FLEN_OFS: flen_reg <= hwdata[15:0];
        `SFT_NDAT_OFS: ndat_reg <= hwdata[2:0];
        `SFT_NIBV_OFS: nibv_reg <= hwdata[27:0];
        `SFT_CSEL_OFS: csel_reg <= hwdata[3:0];
        // Status and unmapped writes are dropped
        default: csel_reg <= csel_reg;
      endcase
    end
  end

  // Overcurrent pins cross into the clock domain
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ocl_sync_reg <= 2'b00;
      och_sync_reg <= 2'b00;
    end
    else
    begin
      ocl_sync_reg <= {ocl_sync_reg[0], oc_low_in};
      och_sync_reg <= {och_sync_reg[0], oc_high_in};
    end
  end

  // Tick divider keeps the ns remainder for fine granularity
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_reg <= 18'h0_0000;
    else if (!en)
      acc_reg <= 18'h0_0000;
    else if (tick)
      acc_reg <= acc_sum - tick_ns;
    else
      acc_reg <= acc_sum;
  end

  // Frame engine, one segment per pulse
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      nidx_reg <= 3'd0;
      seg_cnt_reg <= 16'h0000;
      seg_len_reg <= 16'h0000;
      frm_cnt_reg <= 16'h0000;
      lat_nib_reg <= 28'h000_0000;
      lat_crc_reg <= 4'h0;
      lat_ndat_reg <= 3'd1;
      roll_reg <= 8'h00;
    end
    else if (!en)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        // Start a frame on enable and again after each frame or pause ends
        ST_IDLE:
        begin
          state_reg <= ST_CAL;
          seg_cnt_reg <= 16'h0000;
          seg_len_reg <= `SFT_CAL_TICKS;
          frm_cnt_reg <= 16'h0000;
          lat_nib_reg <= nib_src;
          lat_crc_reg <= crc_sel;
          lat_ndat_reg <= ndat_eff;
          if (roll_en)
            roll_reg <= roll_reg + 8'd1;
        end
        // Calibration, then status, data and checksum nibbles
        ST_CAL, ST_NIB:
        begin
          if (tick)
          begin
            frm_cnt_reg <= frm_cnt_reg + 16'd1;
            seg_cnt_reg <= seg_cnt_reg + 16'd1;
          end
          if (seg_end)
          begin
            seg_cnt_reg <= 16'h0000;
            if (state_reg == ST_CAL)
            begin
              // Status nibble follows calibration
              state_reg <= ST_NIB;
              nidx_reg <= nidx_nxt;
              seg_len_reg <= nib_len;
            end
            else if (!last_nib)
            begin
              // Next data nibble, or checksum after the last one
              nidx_reg <= nidx_nxt;
              seg_len_reg <= nib_len;
            end
            else if (const_en)
            begin
              state_reg <= ST_PAUSE;
              seg_len_reg <= pause_len;
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        // Pause pulse then next frame
        ST_PAUSE:
        begin
          if (tick)
            seg_cnt_reg <= seg_cnt_reg + 16'd1;
          if (seg_end)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Idle lasts one clock right after a tick; the tick floor keeps the
  // next tick far away, so no tick is lost there

  // Active level during the low portion of each pulse
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      act_reg <= 1'b0;
    else
      act_reg <= en && (state_reg != ST_IDLE) &&
        (seg_cnt_reg < {8'h00, lowt_reg});
  end

  // Chosen level code, floating when disabled
  wire [1:0] lvl = !en ? `SFT_LVL_OPEN :
    (act_reg ? act_lvl : inact_lvl);
  // Battery A and B mixed is a fault: float and flag
  wire bat_clash = ((act_lvl == `SFT_LVL_BATA) &&
    (inact_lvl == `SFT_LVL_BATB)) ||
    ((act_lvl == `SFT_LVL_BATB) &&
    (inact_lvl == `SFT_LVL_BATA));
  wire oc_any = ocl_sync_reg[1] || och_sync_reg[1];
  wire drv_ok = en && !bat_clash && !oc_any;

  // Switch enables, never two at once
  assign drv_gnd_en = drv_ok && (lvl == `SFT_LVL_GND);
  assign drv_bata_en = drv_ok && (lvl == `SFT_LVL_BATA);
  assign drv_batb_en = drv_ok && (lvl == `SFT_LVL_BATB);

  // Driver state: level, overcurrents, error
  assign driver_state_word = {bat_clash || oc_any,
    och_sync_reg[1], ocl_sync_reg[1], act_reg};

  // One instance serves one output; CHAN_ID tags it, 0..15

endmodule

// >>> sft_tx_asserts.sv
// Port-level concurrent checks for one SENT transmitter channel
module sft_tx_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus side
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Driver stage
  input wire logic oc_low_in,
  input wire logic oc_high_in,
  input wire logic drv_gnd_en,
  input wire logic drv_bata_en,
  input wire logic drv_batb_en,
  input wire logic [3:0] driver_state_word
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Read accepted on this edge
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  chk_bus_ready: assert property (hreadyout && !hresp) else $error("bus slave stalled or errored");
  chk_one_switch: assert property ($onehot0({drv_gnd_en, drv_bata_en, drv_batb_en}))
    else $error("two driver switches on at once");
  chk_err_floats: assert property (driver_state_word[3] && $past(driver_state_word[3]) |->
    !(drv_gnd_en || drv_bata_en || drv_batb_en)) else $error("output driven while error flagged");
  chk_oc_low_flag: assert property ($rose(oc_low_in) |-> ##[1:4] (driver_state_word[1] && driver_state_word[3]))
    else $error("low side overcurrent not reported");
  chk_oc_high_flag: assert property ($rose(oc_high_in) |-> ##[1:4] (driver_state_word[2] && driver_state_word[3]))
    else $error("high side overcurrent not reported");
  // Synchroniser delay is short of six cycles
  chk_oc_low_clear: assert property (!oc_low_in [*6] |-> !driver_state_word[1])
    else $error("low side overcurrent flag stuck");
  chk_idle_rdata: assert property (!rd_take |=> hrdata == 32'h0000_0000) else $error("read data without a read");
  chk_unmapped_zero: assert property (rd_take && haddr >= 8'h20 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind sft_tx sft_tx_asserts chk (.*);

// >>> test_sft_tx.sv
// Self-checking bench for the SENT transmitter channel
module test_sft_tx;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, oc_low_in = 0, oc_high_in = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 0, rd, nibv;
  wire [31:0] hrdata;
  wire hreadyout, hresp, drv_gnd_en, drv_bata_en, drv_batb_en;
  wire [3:0] driver_state_word;
  int miscompares = 0, check_count = 0, seed = 32'hfcea;
  int exp_q[$]; // Expected segment lengths
  int md[7] = '{0, 2, 3, 4, 4, 5, 6}; // Checksum methods
  int cs[7] = '{0, 0, 0, 1, 9, 11, 0}; // Selector values
  int ofs[5] = '{0, 4, 8, 12, 16};
  int rv[5] = '{32'h0000_0400, 32'h0000_0177, 5, 32'h0000_0200, 6};
  sft_tx dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .oc_low_in(oc_low_in), .oc_high_in(oc_high_in), .drv_gnd_en(drv_gnd_en), .drv_bata_en(drv_bata_en),
    .drv_batb_en(drv_batb_en), .driver_state_word(driver_state_word));
  sft_rx_model rx (.core_clk(core_clk), .rst_n(rst_n), .drv_gnd_en(drv_gnd_en), .drv_bata_en(drv_bata_en),
    .drv_batb_en(drv_batb_en));
  initial forever #12.5 core_clk = ~core_clk;
  // ****
  // Tasks and reference model
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    check_count++;
    if (got !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  // Single word transfer, waits on ready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1);
    rd = hrdata;
  endtask
  // CRC4 table entry, polynomial x4+x3+x2+1
  function automatic int tab(int c);
    int r;
    r = c << 4;
    for (int b = 7; b >= 4; b--)
      if (r[b]) r ^= 'h1D << (b - 4);
    return r & 15;
  endfunction
  function automatic int crc(int m, int s, int d[$]);
    int c;
    if (m == 4) return s < 4 ? crc(s, 0, d) : 0;
    if (m == 5) return s;
    if (m != 0 && m != 1) return m == 3 ? 15 : 0;
    c = 5;
    foreach (d[k]) c = tab(c) ^ d[k];
    if (m == 1) c = tab(c);
    return c;
  endfunction
  // Queue one frame: calibration, status, data, checksum, and a pause only when flen is above zero
  task automatic add_frame(int m, int s, int nd, int rc, int flen);
    int d[$];
    int t;
    for (int k = 1; k <= nd; k++)
      d.push_back(rc >= 0 && k == 4 ? rc / 16 : rc >= 0 && k == 5 ? rc % 16 : (nibv >> (4 * k)) & 15);
    d.push_back(crc(m, s, d));
    exp_q.push_back(56);
    exp_q.push_back(12 + (nibv & 15));
    t = 68 + (nibv & 15);
    foreach (d[k]) exp_q.push_back(12 + d[k]);
    foreach (d[k]) t += 12 + d[k];
    if (flen > 0) exp_q.push_back(flen - t > 12 ? flen - t : 12);
  endtask
  // Configure, send frames, disable, compare segments
  task automatic run(int m, int s, int nd, int rc, int nfr, int flen);
    int t;
    exp_q.delete();
    rx.seg_q.delete();
    for (int f = 0; f < nfr; f++) add_frame(m, s, nd, rc < 0 ? -1 : (rc + f) % 256, flen);
    bus(1, 8'h0C, flen);
    bus(1, 8'h10, nd);
    bus(1, 8'h18, s);
    bus(1, 8'h14, nibv);
    bus(0, 8'h14, 0);
    chk(rd, nibv & 32'h0FFF_FFFF);
    bus(1, 8'h00, 32'h0000_0601 | (m << 4) | (rc >= 0 ? 2 : 0) | (flen > 0 ? 4 : 0));
    t = 0;
    while (rx.seg_q.size() < exp_q.size() && t < 50000)
    begin
      @(posedge core_clk);
      t++;
    end
    chk({driver_state_word[0], drv_bata_en}, 3);
    bus(1, 8'h00, 32'h0000_0600);
    @(posedge core_clk);
    chk({drv_gnd_en, drv_bata_en, drv_batb_en}, 0);
    foreach (exp_q[k]) chk(k < rx.seg_q.size() ? rx.seg_q[k] : -1, exp_q[k]);
  endtask
  task summarize;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1;
    foreach (ofs[k])
    begin
      bus(0, ofs[k], 0);
      chk(rd, rv[k]);
    end
    // Unmapped place reads zero, write lost
    bus(1, 8'h24, 32'h1234_5678);
    bus(0, 8'h24, 0);
    chk(rd, 0);
    bus(1, 8'h04, 10);
    bus(1, 8'h08, 5);
    nibv = $random(seed);
    run(1, 0, 5, 0, 2, 0);
    foreach (md[k])
    begin
      nibv = $random(seed);
      run(md[k], cs[k], 1, -1, 1, 0);
    end
    nibv = $random(seed);
    run(2, 0, 1, -1, 1, 150);
    // Battery A against battery B must float and flag
    bus(1, 8'h00, 32'h0000_0E01);
    repeat (5) @(posedge core_clk);
    chk({driver_state_word[3], drv_gnd_en, drv_bata_en, drv_batb_en}, 8);
    // Battery B active over a floating inactive level
    bus(1, 8'h00, 32'h0000_0600);
    bus(1, 8'h00, 32'h0000_0301);
    repeat (5) @(posedge core_clk);
    chk({drv_gnd_en, drv_bata_en, drv_batb_en, driver_state_word[0]}, 3);
    bus(1, 8'h00, 32'h0000_0601);
    oc_low_in <= 1;
    repeat (5) @(posedge core_clk);
    chk(driver_state_word[3:1], 3'b101);
    oc_low_in <= 0;
    oc_high_in <= 1;
    repeat (6) @(posedge core_clk);
    chk(driver_state_word[3:1], 3'b110);
    oc_high_in <= 0;
    bus(1, 8'h00, 32'h0000_0600);
    summarize();
  end
  // Hang guard, above the whole expected sequence of runs
  initial
  begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
endmodule
